//--- hdl/lcp_pkg.sv
// Register map, field positions and reset values for the line output and charge pump bank
package lcp_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADR_W   = 10;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned SEL_W   = 4;
	localparam int unsigned IDX_W   = 8;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned REG_W   = 16;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] LINE_OUTPUT_STAGE_CONTROL_IDX = 8'h5e;
	localparam logic [IDX_W-1:0] CHARGE_PUMP_ENABLE_CTRL_IDX   = 8'h62;
	localparam logic [IDX_W-1:0] CHARGE_PUMP_POWER_MODE_IDX    = 8'h68;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned LEFT_OUT_SHORT_REMOVE_BIT      = 7;
	localparam int unsigned LEFT_OUT_OUTPUT_STAGE_EN_BIT   = 6;
	localparam int unsigned LEFT_OUT_INTERMEDIATE_EN_BIT   = 5;
	localparam int unsigned LEFT_OUT_INPUT_STAGE_EN_BIT    = 4;
	localparam int unsigned RIGHT_OUT_SHORT_REMOVE_BIT     = 3;
	localparam int unsigned RIGHT_OUT_OUTPUT_STAGE_EN_BIT  = 2;
	localparam int unsigned RIGHT_OUT_INTERMEDIATE_EN_BIT  = 1;
	localparam int unsigned RIGHT_OUT_INPUT_STAGE_EN_BIT   = 0;
	localparam int unsigned CHARGE_PUMP_ENABLE_BIT         = 0;
	localparam int unsigned CHARGE_PUMP_DYNAMIC_POWER_BIT  = 0;

	// Implemented bits: line output uses 7:0, pump registers bit 0
	localparam int unsigned LINE_OUT_FIELD_W = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [LINE_OUT_FIELD_W-1:0] LINE_OUT_RESET = 8'h00;
	localparam logic                        PUMP_EN_RESET  = 1'b0;
	localparam logic                        PUMP_DYN_RESET = 1'b0;
	localparam logic [DAT_W-1:0]            RD_ZERO        = 32'h0000_0000;

endpackage

//--- hdl/lcp_regbank.sv
// Wishbone register bank driving line output stage and charge pump enables
//
// Contract
// - Left short-removal bit seven, resets zero
// - Left output stage enable bit six
// - Left intermediate stage enable bit five
// - Left input stage enable bit four
// - Right short-removal bit three, resets zero
// - Right output stage enable bit two
// - Right intermediate stage enable bit one
// - Right input stage enable bit zero
// - Charge pump enable bit zero
// - Dynamic power select bit zero
module lcp_regbank
	import lcp_pkg::*;
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [lcp_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [lcp_pkg::SEL_W-1:0]   wb_sel_i,
	input  wire logic [lcp_pkg::DAT_W-1:0]   wb_dat_i,
	output logic      [lcp_pkg::DAT_W-1:0]   wb_dat_o,
	output logic                             wb_ack_o,
	output logic                             left_out_short_remove_o,
	output logic                             left_out_output_stage_en_o,
	output logic                             left_out_intermediate_en_o,
	output logic                             left_out_input_stage_en_o,
	output logic                             right_out_short_remove_o,
	output logic                             right_out_output_stage_en_o,
	output logic                             right_out_intermediate_en_o,
	output logic                             right_out_input_stage_en_o,
	output logic                             charge_pump_enable_o,
	output logic                             charge_pump_dynamic_power_o
);
	import lcp_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [LINE_OUT_FIELD_W-1:0] line_out_r;
	logic [LINE_OUT_FIELD_W-1:0] line_out_nxt;
	logic                        pump_en_r;
	logic                        pump_en_nxt;
	logic                        pump_dyn_r;
	logic                        pump_dyn_nxt;
	logic                        ack_r;
	logic                        ack_nxt;
	logic [DAT_W-1:0]            rdat_r;
	logic [DAT_W-1:0]            rdat_nxt;
	logic [IDX_W-1:0]            idx;
	logic                        req;
	logic                        wr_lo;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Accept a request once; the ack pulse itself blocks a second take
	assign idx   = wb_adr_i[IDX_LSB +: IDX_W];
	assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr_lo = req & wb_we_i & wb_sel_i[0]; // All fields live in byte lane 0

	// Next register values; a write lands with the ack so enables move at once
	always_comb begin
		line_out_nxt = line_out_r;
		pump_en_nxt  = pump_en_r;
		pump_dyn_nxt = pump_dyn_r;
		ack_nxt      = req;
		rdat_nxt     = rdat_r;
		if (wr_lo) begin
			unique case (idx)
				LINE_OUTPUT_STAGE_CONTROL_IDX: begin
					line_out_nxt = wb_dat_i[LINE_OUT_FIELD_W-1:0];
				end
				CHARGE_PUMP_ENABLE_CTRL_IDX: begin
					pump_en_nxt = wb_dat_i[CHARGE_PUMP_ENABLE_BIT];
				end
				CHARGE_PUMP_POWER_MODE_IDX: begin
					pump_dyn_nxt = wb_dat_i[CHARGE_PUMP_DYNAMIC_POWER_BIT];
				end
				default: begin
					line_out_nxt = line_out_r; // Unmapped writes are dropped
				end
			endcase
		end
		// Read data captured with the ack; unmapped and upper bits read zero
		if (req) begin
			rdat_nxt = RD_ZERO;
			if (!wb_we_i) begin
				unique case (idx)
					LINE_OUTPUT_STAGE_CONTROL_IDX: begin
						rdat_nxt[LINE_OUT_FIELD_W-1:0] = line_out_r;
					end
					CHARGE_PUMP_ENABLE_CTRL_IDX: begin
						rdat_nxt[CHARGE_PUMP_ENABLE_BIT] = pump_en_r;
					end
					CHARGE_PUMP_POWER_MODE_IDX: begin
						rdat_nxt[CHARGE_PUMP_DYNAMIC_POWER_BIT] = pump_dyn_r;
					end
					default: begin
						rdat_nxt = RD_ZERO;
					end
				endcase
			end
		end
	end

	// Register stage; reset acts whatever ce_i is, otherwise clock enable low freezes everything, bus included
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_out_r <= LINE_OUT_RESET;
			pump_en_r  <= PUMP_EN_RESET;
			pump_dyn_r <= PUMP_DYN_RESET;
			ack_r      <= 1'b0;
			rdat_r     <= RD_ZERO;
		end else if (ce_i) begin
			line_out_r <= line_out_nxt;
			pump_en_r  <= pump_en_nxt;
			pump_dyn_r <= pump_dyn_nxt;
			ack_r      <= ack_nxt;
			rdat_r     <= rdat_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs to the analogue stages
	// ----------------------------------------------------------------
	// Sequencing is left to the host; no interlock, so a bad order reaches the pins
	assign wb_ack_o                    = ack_r;
	assign wb_dat_o                    = rdat_r;
	assign left_out_short_remove_o     = line_out_r[LEFT_OUT_SHORT_REMOVE_BIT];
	assign left_out_output_stage_en_o  = line_out_r[LEFT_OUT_OUTPUT_STAGE_EN_BIT];
	assign left_out_intermediate_en_o  = line_out_r[LEFT_OUT_INTERMEDIATE_EN_BIT];
	assign left_out_input_stage_en_o   = line_out_r[LEFT_OUT_INPUT_STAGE_EN_BIT];
	assign right_out_short_remove_o    = line_out_r[RIGHT_OUT_SHORT_REMOVE_BIT];
	assign right_out_output_stage_en_o = line_out_r[RIGHT_OUT_OUTPUT_STAGE_EN_BIT];
	assign right_out_intermediate_en_o = line_out_r[RIGHT_OUT_INTERMEDIATE_EN_BIT];
	assign right_out_input_stage_en_o  = line_out_r[RIGHT_OUT_INPUT_STAGE_EN_BIT];
	assign charge_pump_enable_o        = pump_en_r;
	assign charge_pump_dynamic_power_o = pump_dyn_r;

endmodule

//--- bench/lcp_regbank_monitor.sv
// Checker for the line output and charge pump register bank
module lcp_regbank_monitor
	import lcp_pkg::*;
(
	input wire logic                      clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [lcp_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [lcp_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [lcp_pkg::DAT_W-1:0] wb_dat_i, wb_dat_o,
	input wire logic                      left_out_short_remove_o, left_out_output_stage_en_o,
	input wire logic                      left_out_intermediate_en_o, left_out_input_stage_en_o,
	input wire logic                      right_out_short_remove_o, right_out_output_stage_en_o,
	input wire logic                      right_out_intermediate_en_o, right_out_input_stage_en_o,
	input wire logic                      charge_pump_enable_o, charge_pump_dynamic_power_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [9:0] outs;
	// Enables gathered in register bit order, pump bits on top
	assign outs = {charge_pump_dynamic_power_o, charge_pump_enable_o, left_out_short_remove_o,
		left_out_output_stage_en_o, left_out_intermediate_en_o, left_out_input_stage_en_o,
		right_out_short_remove_o, right_out_output_stage_en_o, right_out_intermediate_en_o,
		right_out_input_stage_en_o};
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_wr(logic [7:0] idx);
		s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx);
	endsequence
	a_ack_on_take: assert property (s_take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_left_bits_wr: assert property (s_wr(8'h5e) |=> outs[7:4] == $past(wb_dat_i[7:4]))
		else $error("left enables differ from write");
	a_right_bits_wr: assert property (s_wr(8'h5e) |=> outs[3:0] == $past(wb_dat_i[3:0]))
		else $error("right enables differ from write");
	a_pump_en_wr: assert property (s_wr(8'h62) |=> outs[8] == $past(wb_dat_i[0]))
		else $error("pump enable differs from write");
	a_pump_dyn_wr: assert property (s_wr(8'h68) |=> outs[9] == $past(wb_dat_i[0]))
		else $error("dynamic power differs from write");
	a_line_readback: assert property (s_take ##0 (!wb_we_i && wb_adr_i[9:2] == 8'h5e) |=>
		wb_dat_o == {24'h0, outs[7:0]}) else $error("line readback wrong");
	a_outs_hold: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i) |=>
		$stable(outs)) else $error("enables moved without a write");
	a_reset_clears: assert property (disable iff (1'b0) rst_i |=> outs == 10'h0 && !wb_ack_o)
		else $error("reset left an enable set");
endmodule
bind lcp_regbank lcp_regbank_monitor i_mon (.*);

//--- bench/lcp_regbank_tb.sv
// Self-checking bench for the line output and charge pump register bank
module lcp_regbank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lcp_pkg::*;
	logic             clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [SEL_W-1:0] wb_sel_i = '0;
	logic [DAT_W-1:0] wb_dat_i = '0, wb_dat_o, q, rv;
	logic             wb_ack_o, left_out_short_remove_o, left_out_output_stage_en_o;
	logic             left_out_intermediate_en_o, left_out_input_stage_en_o;
	logic             right_out_short_remove_o, right_out_output_stage_en_o;
	logic             right_out_intermediate_en_o, right_out_input_stage_en_o;
	logic             charge_pump_enable_o, charge_pump_dynamic_power_o, w, m_en, m_dyn;
	logic [7:0]       m_line;
	logic [9:0]       a, adrs[4] = '{10'h178, 10'h188, 10'h1a0, 10'h17c};
	int               fails = 0, checked = 0, seed = 7;
	always #2.5 clk_i = ~clk_i;
	lcp_regbank i_dut (.*);
	// Expected read data from the bench's own copy of the registers
	function automatic logic [31:0] rd_exp(input logic [9:0] ad);
		case (ad[9:2])
			8'h5e: return {24'h0, m_line};
			8'h62: return {31'h0, m_en};
			8'h68: return {31'h0, m_dyn};
			default: return 32'h0;
		endcase
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Classic cycle; clock enable wobbles while waiting to prove stalls are held
	task bus(input logic we, input logic [9:0] ad, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, ad, d, s};
		forever begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
			ce_i <= ($random(seed) & 3) != 0;
		end
		{wb_cyc_i, wb_stb_i, ce_i} <= 3'b001;
		q = wb_dat_o;
		if (we && s[0]) case (ad[9:2])
			8'h5e: m_line = d[7:0];
			8'h62: m_en = d[0];
			8'h68: m_dyn = d[0];
			default: ;
		endcase
		chk({22'h0, charge_pump_dynamic_power_o, charge_pump_enable_o, left_out_short_remove_o,
			left_out_output_stage_en_o, left_out_intermediate_en_o, left_out_input_stage_en_o,
			right_out_short_remove_o, right_out_output_stage_en_o, right_out_intermediate_en_o,
			right_out_input_stage_en_o}, {22'h0, m_dyn, m_en, m_line});
	endtask
	initial begin
		{m_line, m_en, m_dyn} = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		for (int r = 0; r < 2; r++) begin
			foreach (adrs[i]) begin
				bus(0, adrs[i], 32'h0, 4'h0);
				chk(q, 32'h0);
			end
			// Ordered power-up: input stages, wait, intermediate, output, short last
			bus(1, 10'h178, 32'h11, 4'h1);
			repeat (4000) @(posedge clk_i);
			bus(1, 10'h178, 32'h33, 4'h1);
			bus(1, 10'h178, 32'h77, 4'h1);
			bus(1, 10'h178, 32'hff, 4'h1);
			repeat (60) begin
				rv = $random(seed);
				w = rv[4];
				a = adrs[rv[1:0]];
				bus(w, a, $random(seed), rv[11:8]);
				chk(q, w ? 32'h0 : rd_exp(a));
			end
			rst_i <= 1;
			repeat (3) @(posedge clk_i);
			rst_i <= 0;
			{m_line, m_en, m_dyn} = '0;
		end
		test_done;
	end
	initial begin
		#100us;
		fails++;
		test_done;
	end
endmodule
